/* hw/sef_pkg.sv */
// Purpose: shared constants and types for the serial eeprom front end and its master
// Assumes: 40 MHz system clock on both ends
// Notes: opcodes and controller register map are local choices
package sef_pkg;
  localparam int CLK_NS = 25;
  localparam int T_WR_MS = 5;
  // longest write time, rounded down to whole cycles
  localparam int WR_CYC = (T_WR_MS * 1000000) / CLK_NS;
  localparam int HALF_NS = 100;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int MEM_BYTES = 32768;
  localparam int PAGE_BYTES = 64;
  localparam int SEC_BYTES = 64;
  localparam int SERIAL_BITS = 128;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_SECWR = 8'h82;
  localparam logic [7:0] OP_SERRD = 8'h83;
  localparam logic [7:0] OP_SECLK = 8'h8A;
  localparam logic [7:0] OP_SECRD = 8'h8B;
  localparam int ST_BUSY = 0;
  localparam int ST_WL = 1;
  localparam int ST_BP = 2;
  localparam int ST_LOCK = 7;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [7:0] RD_VOID = 8'hFF;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX = 4'h4;
  localparam logic [3:0] REG_RX = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int CT_GO = 0;
  localparam int CT_END = 1;
  localparam int CT_MODE3 = 2;
  localparam int CT_PAUSE = 3;
  localparam int CT_WPN = 4;
  localparam logic [7:0] CTRL_RST = 8'h10;
  typedef enum logic [3:0] {
    PH_CMD = 4'h1, PH_ADR = 4'h2, PH_DAT = 4'h4, PH_OUT = 4'h8
  } sef_ph_e;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1, HS_LOW = 4'h2, HS_HIGH = 4'h4, HS_END = 4'h8
  } sef_hs_e;
endpackage

/* hw/sef_if.sv */
// Purpose: serial link between master and eeprom front end
// Assumes: serial_out_oe_n is low while the device drives serial_out
// Notes: serial_line reads high when released, as a pulled-up pin would
`timescale 1ns/100ps
interface sef_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic hold_n;
  logic wp_n;
  logic serial_out;
  logic serial_out_oe_n;
  wire serial_line;
  assign serial_line = serial_out_oe_n ? 1'b1 : serial_out;
  modport dev (input sclk, input cs_n, input serial_in, input hold_n, input wp_n,
               output serial_out, output serial_out_oe_n);
  modport host (output sclk, output cs_n, output serial_in, output hold_n, output wp_n,
                input serial_line);
endinterface

/* hw/sef_dev.sv */
// Purpose: eeprom serial front end with array, secure sector and serial id
// Assumes: link pins are asynchronous and sampled by clk; hold_n and wp_n idle high
// Notes: array has no reset, it stands for non-volatile storage
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module sef_dev #(
  parameter int WR_CYCLES = sef_pkg::WR_CYC,
  parameter logic [sef_pkg::SERIAL_BITS-1:0] SERIAL_VAL = 128'h0123456789ABCDEF0F1E2D3C4B5A6978 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  sef_if.dev bus
);
  import sef_pkg::*;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic psck;
    logic pcs;
    logic sel;
    logic held;
    sef_ph_e ph;
    logic [2:0] bitc;
    logic [7:0] shin;
    logic [7:0] cmd;
    logic [7:0] shout;
    logic [7:0] sr_in;
    logic dout;
    logic ab;
    logic got;
    logic aok;
    logic [15:0] addr;
    logic [8:0] wpage;
    logic [63:0] mask;
    logic [63:0][7:0] pbuf;
    logic [63:0][7:0] sec;
    logic lock;
    logic [1:0] bp;
    logic write_latch;
    logic busy;
    logic seclk;
    logic wmem;
    logic wsec;
    logic [6:0] widx;
    logic [31:0] tmr;
  } sef_dev_s;

  sef_dev_s s_ff;
  sef_dev_s nxt_s;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic sck, csn, si, hldn, wpn;
  logic mem_we;

  assign sck = s_ff.sy2[4];
  assign csn = s_ff.sy2[3];
  assign si = s_ff.sy2[2];
  assign hldn = s_ff.sy2[1];
  assign wpn = s_ff.sy2[0];
  assign mem_we = s_ff.busy && s_ff.wmem && !s_ff.widx[6] && s_ff.mask[s_ff.widx[5:0]];
  assign bus.serial_out = s_ff.dout;
  assign bus.serial_out_oe_n = !(s_ff.sel && !s_ff.held && s_ff.ph == PH_OUT);

  always_comb begin
    logic [7:0] nb;
    logic [15:0] la;
    logic [7:0] st;
    logic [7:0] rb;
    logic prot;
    logic go;
    nb = '0;
    la = '0;
    st = '0;
    rb = '0;
    prot = 1'b0;
    go = 1'b0;
    nxt_s = s_ff;
    nxt_s.sy1 = {bus.sclk, bus.cs_n, bus.serial_in, bus.hold_n, bus.wp_n};
    nxt_s.sy2 = s_ff.sy1;
    nxt_s.psck = sck;
    nxt_s.pcs = csn;
    nb = {s_ff.shin[6:0], si};
    la = (s_ff.ph == PH_ADR) ? {s_ff.addr[7:0], nb} : s_ff.addr;
    st[ST_BUSY] = s_ff.busy;
    st[ST_WL] = s_ff.write_latch;
    st[ST_BP +: 2] = s_ff.bp;
    st[ST_LOCK] = s_ff.lock;
    if (s_ff.cmd == OP_READ) begin
      rb = mem[la[14:0]];
    end else if (s_ff.cmd == OP_SECRD) begin
      rb = (la[10:9] == 2'h0) ? s_ff.sec[la[5:0]] : RD_VOID;
    end else if (s_ff.cmd == OP_SERRD) begin
      rb = la[9] ? SERIAL_VAL[{la[3:0], 3'h0} +: 8] : RD_VOID;
    end else begin
      rb = st;
    end
    unique case (s_ff.bp)
      BP_QTR: prot = (s_ff.wpage[8:7] == 2'h3);
      BP_HALF: prot = s_ff.wpage[8];
      BP_ALL: prot = 1'b1;
      default: prot = 1'b0;
    endcase
    // copy engine; runs regardless of select
    if (s_ff.busy) begin
      if (!s_ff.widx[6]) begin
        if (s_ff.wsec && s_ff.mask[s_ff.widx[5:0]]) begin
          nxt_s.sec[s_ff.widx[5:0]] = s_ff.pbuf[s_ff.widx[5:0]];
        end
        nxt_s.widx = s_ff.widx + 7'h01;
      end
      if (s_ff.tmr == 32'h0) begin
        nxt_s.busy = 1'b0;
      end else begin
        nxt_s.tmr = s_ff.tmr - 32'h1;
      end
    end
    // pause changes state only while the clock is low, except that deselect clears it
    if (csn) begin
      nxt_s.held = 1'b0;
    end else if (!sck) begin
      nxt_s.held = !hldn;
    end
    if (s_ff.pcs && !csn) begin
      nxt_s.sel = 1'b1;
      nxt_s.ph = PH_CMD;
      nxt_s.bitc = 3'h0;
      nxt_s.got = 1'b0;
    end else if (!s_ff.pcs && csn) begin
      nxt_s.sel = 1'b0;
      if (s_ff.sel && s_ff.ph == PH_DAT && s_ff.bitc == 3'h0 && s_ff.write_latch && !s_ff.busy) begin
        if (s_ff.cmd == OP_WRITE) begin
          go = s_ff.got && !prot;
        end else if (s_ff.cmd == OP_SECWR) begin
          go = s_ff.got && s_ff.aok && !s_ff.seclk;
        end else if (s_ff.cmd == OP_WRSR) begin
          go = s_ff.got && !(s_ff.lock && !wpn);
        end else if (s_ff.cmd == OP_SECLK) begin
          go = 1'b1;
        end
      end
      if (go) begin
        nxt_s.busy = 1'b1;
        nxt_s.write_latch = 1'b0;
        nxt_s.widx = 7'h00;
        nxt_s.tmr = 32'(WR_CYCLES - 1);
        nxt_s.wmem = (s_ff.cmd == OP_WRITE);
        nxt_s.wsec = (s_ff.cmd == OP_SECWR);
        if (s_ff.cmd == OP_WRSR) begin
          nxt_s.lock = s_ff.sr_in[ST_LOCK];
          nxt_s.bp = s_ff.sr_in[ST_BP +: 2];
        end
        if (s_ff.cmd == OP_SECLK) begin
          nxt_s.seclk = 1'b1;
        end
      end
    end else if (s_ff.sel && !s_ff.held) begin
      // edges are taken in either idle level of the clock
      if (sck && !s_ff.psck) begin
        nxt_s.shin = nb;
        nxt_s.bitc = s_ff.bitc + 3'h1;
        if (s_ff.bitc == 3'h7) begin
          unique case (s_ff.ph)
            PH_CMD: begin
              nxt_s.cmd = nb;
              nxt_s.ab = 1'b0;
              nxt_s.ph = PH_DAT;
              if (s_ff.busy && nb != OP_RDSR) begin
                nxt_s.cmd = 8'h00;
              end else if (nb == OP_WREN) begin
                nxt_s.write_latch = 1'b1;
                nxt_s.cmd = 8'h00;
              end else if (nb == OP_WRDI) begin
                nxt_s.write_latch = 1'b0;
                nxt_s.cmd = 8'h00;
              end else if (nb == OP_RDSR) begin
                nxt_s.shout = st;
                nxt_s.ph = PH_OUT;
              end else if (nb == OP_READ || nb == OP_WRITE || nb == OP_SECWR ||
                           nb == OP_SECRD || nb == OP_SERRD) begin
                nxt_s.ph = PH_ADR;
              end else if (nb != OP_WRSR && nb != OP_SECLK) begin
                nxt_s.cmd = 8'h00;
              end
            end
            PH_ADR: begin
              nxt_s.addr = la;
              nxt_s.ab = 1'b1;
              if (s_ff.ab) begin
                nxt_s.wpage = la[14:6];
                nxt_s.aok = (la[10:9] == 2'h0);
                nxt_s.mask = '0;
                if (s_ff.cmd == OP_WRITE || s_ff.cmd == OP_SECWR) begin
                  nxt_s.ph = PH_DAT;
                end else begin
                  nxt_s.shout = rb;
                  nxt_s.addr = la + 16'h0001;
                  nxt_s.ph = PH_OUT;
                end
              end
            end
            PH_DAT: begin
              nxt_s.got = 1'b1;
              nxt_s.sr_in = nb;
              // page write wraps within its page
              nxt_s.pbuf[s_ff.addr[5:0]] = nb;
              nxt_s.mask[s_ff.addr[5:0]] = 1'b1;
              nxt_s.addr = {s_ff.addr[15:6], s_ff.addr[5:0] + 6'h01};
            end
            PH_OUT: begin
              nxt_s.shout = rb;
              nxt_s.addr = s_ff.addr + 16'h0001;
            end
          endcase
        end
      end else if (!sck && s_ff.psck && s_ff.ph == PH_OUT) begin
        nxt_s.dout = s_ff.shout[7];
        nxt_s.shout = {s_ff.shout[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.sy1 <= 5'h1F;
      s_ff.sy2 <= 5'h1F;
      s_ff.pcs <= 1'b1;
      s_ff.ph <= PH_CMD;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[{s_ff.wpage, s_ff.widx[5:0]}] <= s_ff.pbuf[s_ff.widx[5:0]];
    end
  end
endmodule

/* hw/sef_host.sv */
// Purpose: byte-wide spi master for the eeprom front end
// Assumes: software sequences opcodes, write enables and addresses
// Notes: clock half period is HALF cycles of clk
`timescale 1ns/100ps
module sef_host #(
  parameter int HALF = sef_pkg::HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  sef_if.host bus
);
  import sef_pkg::*;

  typedef struct packed {
    sef_hs_e st;
    logic [7:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rdata;
    logic [2:0] bitn;
    logic [7:0] cnt;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic endf;
    logic [1:0] sy;
  } sef_host_s;

  sef_host_s s_ff;
  sef_host_s nxt_s;
  logic idle_lvl;

  assign idle_lvl = s_ff.ctrl[CT_MODE3];
  assign bus.sclk = s_ff.sclk;
  assign bus.cs_n = s_ff.cs_n;
  assign bus.serial_in = s_ff.mosi;
  assign bus.hold_n = !s_ff.ctrl[CT_PAUSE];
  assign bus.wp_n = s_ff.ctrl[CT_WPN];
  assign rdata = s_ff.rdata;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sy = {s_ff.sy[0], bus.serial_line};
    nxt_s.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        REG_CTRL: nxt_s.rdata = s_ff.ctrl;
        REG_TX: nxt_s.rdata = s_ff.tx;
        REG_RX: nxt_s.rdata = s_ff.rx;
        REG_STAT: nxt_s.rdata = {6'h00, !s_ff.cs_n, s_ff.st != HS_IDLE};
        default: nxt_s.rdata = 8'h00;
      endcase
    end
    if (wr && addr == REG_TX) begin
      nxt_s.tx = wdata;
    end
    if (wr && addr == REG_CTRL) begin
      nxt_s.ctrl = wdata & 8'hFE;
    end
    unique case (s_ff.st)
      HS_IDLE: begin
        if (s_ff.cs_n) begin
          nxt_s.sclk = idle_lvl;
        end
        if (wr && addr == REG_CTRL && wdata[CT_GO]) begin
          // select falls first so the slave sees a fresh instruction
          nxt_s.cs_n = 1'b0;
          nxt_s.endf = wdata[CT_END];
          nxt_s.mosi = s_ff.tx[7];
          nxt_s.bitn = 3'h7;
          nxt_s.cnt = 8'(HALF - 1);
          nxt_s.st = HS_LOW;
        end
      end
      HS_LOW: begin
        nxt_s.sclk = 1'b0;
        // freeze only with the clock low, so a pause asked in the high phase starts at the next low phase
        if (!s_ff.ctrl[CT_PAUSE]) begin
          if (s_ff.cnt == 8'h00) begin
            nxt_s.sclk = 1'b1;
            nxt_s.cnt = 8'(HALF - 1);
            nxt_s.st = HS_HIGH;
          end else begin
            nxt_s.cnt = s_ff.cnt - 8'h01;
          end
        end
      end
      HS_HIGH: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.rx = {s_ff.rx[6:0], s_ff.sy[1]};
          nxt_s.cnt = 8'(HALF - 1);
          if (s_ff.bitn == 3'h0) begin
            nxt_s.sclk = idle_lvl;
            nxt_s.st = s_ff.endf ? HS_END : HS_IDLE;
          end else begin
            nxt_s.sclk = 1'b0;
            nxt_s.bitn = s_ff.bitn - 3'h1;
            nxt_s.mosi = s_ff.tx[s_ff.bitn - 3'h1];
            nxt_s.st = HS_LOW;
          end
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      HS_END: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.cs_n = 1'b1;
          nxt_s.st = HS_IDLE;
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.st <= HS_IDLE;
      s_ff.ctrl <= CTRL_RST;
      s_ff.cs_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

/* verif/sef_monitor.sv */
// Purpose: wire checks on the link between master and front end
// Assumes: same clk as both ends, sclk half period of 4 clk or more
// Notes: device pin latency taken as 3 clk, bounds leave one spare
`timescale 1ns/100ps
module sef_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic seen_fall_ff;
  logic cs_prev_ff;
  logic idle_ff;
  logic [3:0] since_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cs_n held low through reset counts as a select edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_fall_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
      idle_ff <= 1'b0;
      since_ff <= 4'hF;
    end else begin
      cs_prev_ff <= cs_n;
      if (cs_prev_ff && !cs_n) begin
        seen_fall_ff <= 1'b1;
        idle_ff <= sclk;
      end
      if ($fell(sclk)) begin
        since_ff <= 4'h0;
      end else if (since_ff != 4'hF) begin
        since_ff <= since_ff + 4'h1;
      end
    end
  end
  sequence s_desel;
    cs_n [*5];
  endsequence
  sequence s_paused;
    (!hold_n && !sclk && !cs_n) [*5];
  endsequence
  a_desel_float: assert property (s_desel |-> serial_out_oe_n)
    else $error("output driven while deselected");
  a_first_select: assert property (!seen_fall_ff |-> serial_out_oe_n)
    else $error("output driven before first select");
  a_pause_float: assert property (s_paused |-> serial_out_oe_n)
    else $error("output driven while paused");
  // a rise-launched change would land at 6 or more
  a_out_on_fall: assert property (!serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out)
    |-> since_ff <= 4'h4) else $error("output changed away from falling sclk");
  a_opcode_first: assert property ($fell(serial_out_oe_n) |-> !$past(cs_n, 60))
    else $error("output before a full opcode");
  a_din_held: assert property ($rose(sclk) && !cs_n |-> $stable(serial_in) [*3])
    else $error("serial_in moved around rising sclk");
  a_sclk_half: assert property ($changed(sclk) && !cs_n |=> $stable(sclk) [*2])
    else $error("sclk phase too short");
  a_end_idle: assert property ($rose(cs_n) |-> sclk == idle_ff)
    else $error("sclk idle level differs at frame end");
endmodule

/* verif/spi_eeprom_front_end_test.sv */
// Purpose: end to end test of master and front end over the link
// Assumes: write cycle cut to 200 clk, sclk half period 4 clk
// Notes: array is not reset, so only written bytes are read back
`timescale 1ns/100ps
module spi_eeprom_front_end_test;
  import sef_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] flags = 8'h10;
  logic [7:0] r;
  int mismatches = 0;
  int cmp_count = 0;
  sef_if lnk();
  // palindromic id, arbitrary value, so byte order cannot matter
  sef_dev #(.WR_CYCLES(200), .SERIAL_VAL(128'h11223344556677888877665544332211)) i_sef_dev (.clk(clk),
    .rst_n(rst_n), .bus(lnk));
  sef_host i_sef_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .bus(lnk));
  sef_monitor i_sef_monitor (.clk(clk), .rst_n(rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .serial_in(lnk.serial_in),
    .hold_n(lnk.hold_n), .wp_n(lnk.wp_n), .serial_out(lnk.serial_out), .serial_out_oe_n(lnk.serial_out_oe_n));
  always #12.5 clk = ~clk;
  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic fin(output logic [7:0] rx);
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 200 && s[0] === 1'b1; i++) rd_reg(REG_STAT, s);
    if (s[0] !== 1'b0) begin
      mismatches++;
      $display("Error link busy flag expected 0 seen %b", s[0]);
    end
    rd_reg(REG_RX, rx);
  endtask
  task automatic xb(input logic [7:0] tx, input logic last, output logic [7:0] rx);
    wr_reg(REG_TX, tx);
    wr_reg(REG_CTRL, flags | {6'h00, last, 1'b1});
    fin(rx);
  endtask
  task automatic cmd1(input logic [7:0] op);
    xb(op, 1'b1, r);
  endtask
  task automatic op3(input logic [7:0] op, input logic [15:0] a);
    xb(op, 1'b0, r);
    xb(a[15:8], 1'b0, r);
    xb(a[7:0], 1'b0, r);
  endtask
  task automatic wr1(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
    op3(op, a);
    xb(d, 1'b1, r);
  endtask
  task automatic rd1(input logic [7:0] op, input logic [15:0] a, input logic [7:0] exp);
    op3(op, a);
    xb(8'h00, 1'b1, r);
    chk("read byte", exp, r);
  endtask
  task automatic sr(input logic [7:0] exp);
    xb(OP_RDSR, 1'b0, r);
    xb(8'h00, 1'b1, r);
    chk("status", exp, r);
  endtask
  // status reads are the only traffic allowed while busy
  task automatic wait_rdy;
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 40 && s[0] === 1'b1; i++) begin
      xb(OP_RDSR, 1'b0, s);
      xb(8'h00, 1'b1, s);
    end
    if (s[0] !== 1'b0) begin
      mismatches++;
      $display("Error busy_flag expected 0 seen %b", s[0]);
    end
  endtask
  task automatic wsr(input logic [7:0] v);
    cmd1(OP_WREN);
    xb(OP_WRSR, 1'b0, r);
    xb(v, 1'b1, r);
    wait_rdy;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(REG_CTRL, r);
    chk("ctrl reset", CTRL_RST, r);
    rd_reg(4'h2, r);
    chk("unmapped", 8'h00, r);
    sr(8'h00);
    cmd1(OP_WREN);
    sr(8'h02);
    op3(OP_WRITE, 16'h013E);
    xb(8'hA1, 1'b0, r);
    xb(8'hB2, 1'b0, r);
    xb(8'hC3, 1'b1, r);
    cmd1(OP_WREN);
    wait_rdy;
    sr(8'h00);
    rd1(OP_READ, 16'h0100, 8'hC3);
    flags = 8'h14;
    wr_reg(REG_CTRL, flags);
    op3(OP_READ, 16'h013E);
    xb(8'h00, 1'b0, r);
    chk("mode 3 read", 8'hA1, r);
    xb(8'h00, 1'b1, r);
    chk("mode 3 read", 8'hB2, r);
    flags = 8'h10;
    wr_reg(REG_CTRL, flags);
    op3(OP_READ, 16'h0100);
    wr_reg(REG_TX, 8'h00);
    wr_reg(REG_CTRL, 8'h1B);
    repeat (40) @(posedge clk);
    chk("paused line", 8'h01, {7'h00, lnk.serial_out_oe_n});
    rd_reg(REG_STAT, r);
    chk("paused busy", 8'h01, {7'h00, r[0]});
    wr_reg(REG_CTRL, 8'h12);
    fin(r);
    chk("resumed", 8'hC3, r);
    repeat (8) @(posedge clk);
    chk("deselected line", 8'h01, {7'h00, lnk.serial_out_oe_n});
    for (int bp = 1; bp < 4; bp++) begin
      wsr({4'h0, bp[1:0], 2'b00});
      cmd1(OP_WREN);
      wr1(OP_WRITE, bp == 1 ? 16'h6000 : bp == 2 ? 16'h4000 : 16'h0000, 8'h55);
      sr({4'h0, bp[1:0], 2'b10});
    end
    wsr(8'h8C);
    flags = 8'h00;
    wsr(8'h00);
    sr(8'h8E);
    flags = 8'h10;
    wsr(8'h00);
    sr(8'h00);
    cmd1(OP_WREN);
    wr1(OP_SECWR, 16'hF805, 8'h5A);
    wait_rdy;
    rd1(OP_SECRD, 16'hF9C5, 8'h5A);
    cmd1(OP_WREN);
    wr1(OP_SECWR, 16'h0205, 8'h66);
    sr(8'h02);
    cmd1(OP_SECLK);
    wait_rdy;
    cmd1(OP_WREN);
    wr1(OP_SECWR, 16'h0005, 8'h77);
    sr(8'h02);
    rd1(OP_SECRD, 16'h0005, 8'h5A);
    rd1(OP_SERRD, 16'h0600, 8'h11);
    rd1(OP_SERRD, 16'h0000, 8'hFF);
    close_out;
  end
  // whole run is well under a fifth of this span
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule
